// *** src/lspr_pkg.sv ***
package lspr_pkg;

   // Switch geometry.
   localparam int NPORT = 4;
   localparam int PW = 2;
   localparam int AW = 32;
   localparam int TAGW = 5;
   localparam int NTAG = 8;
   localparam int SLW = 3;
   localparam int RAW = 12;

   // Register byte offsets; each port owns a 32-byte block.
   localparam logic [RAW-1:0] REG_PORT_STRIDE = 12'h020;
   localparam logic [RAW-1:0] REG_MASK = 12'h000;
   localparam logic [RAW-1:0] REG_DFLT = 12'h004;
   localparam logic [RAW-1:0] REG_BASE = 12'h008;
   localparam logic [RAW-1:0] REG_LIMIT = 12'h00C;
   localparam logic [RAW-1:0] REG_PSTAT = 12'h010;
   localparam logic [RAW-1:0] REG_CTRL = 12'h100;
   localparam logic [RAW-1:0] REG_GSTAT = 12'h104;

   // Field positions.
   localparam int CTRL_PART_EN_BIT = 0;
   localparam int PSTAT_SEC_BIT = 0;

   // Values after reset.
   localparam logic [NPORT-1:0] MASK_RST = 4'hF;
   localparam logic [PW-1:0] DFLT_RST = 2'h0;
   localparam logic [AW-1:0] BASE_RST = 32'hFFFFFFFF;
   localparam logic [AW-1:0] LIMIT_RST = 32'h00000000;
   localparam logic PART_EN_RST = 1'b1;
   localparam logic [NPORT-1:0] PORT_SEC_RST = 4'hE;

   // Cycles the strap synchroniser needs before its output is trusted.
   localparam logic [1:0] STRAP_SETTLE = 2'h3;

   // Packet kinds seen by the router.
   typedef enum logic [2:0] {
      KIND_RD_NP = 3'h0,
      KIND_WR_P = 3'h1,
      KIND_WR_NP = 3'h2,
      KIND_RESP = 3'h3,
      KIND_FLUSH = 3'h4,
      KIND_FENCE = 3'h5
   } lspr_kind_e;

   // Handling chosen for one packet.
   typedef enum logic [1:0] {
      ACT_FWD = 2'h0,
      ACT_RESP = 2'h1,
      ACT_DROP = 2'h2
   } lspr_act_e;

   // Ingress packet header.
   typedef struct packed {
      lspr_kind_e kind;
      logic [PW-1:0] port;
      logic [AW-1:0] addr;
      logic [TAGW-1:0] tag;
      logic compat;
   } lspr_pkt_s;

   // Routing result handed to the egress side.
   typedef struct packed {
      lspr_act_e act;
      logic [PW-1:0] ing;
      logic [PW-1:0] port;
      lspr_pkt_s pkt;
   } lspr_out_s;

   // Nonposted packets need an answer when they cannot be forwarded.
   function automatic logic is_np(input lspr_kind_e k);
      return (k == KIND_RD_NP) || (k == KIND_WR_NP) || (k == KIND_FLUSH);
   endfunction

endpackage

// *** src/lspr_addr_dec.sv ***
`timescale 1ns/1ps
`default_nettype none

module lspr_addr_dec
   import lspr_pkg::*;
(
   // Request address.
   input wire logic [AW-1:0] addr,
   // Windows of every port and the port types.
   input wire logic [NPORT-1:0][AW-1:0] base,
   input wire logic [NPORT-1:0][AW-1:0] limit,
   input wire logic [NPORT-1:0] port_sec,
   // Decode result.
   output logic hit,
   output logic [PW-1:0] hit_port
);

   // Per-port window match; only secondary ports claim addresses.
   logic [NPORT-1:0] match;

   genvar g;
   generate
      for (g = 0; g < NPORT; g++) begin : g_win
         assign match[g] = port_sec[g] && (addr >= base[g]) && (addr <= limit[g]);
      end
   endgenerate

   // Lowest numbered window wins when software lets windows overlap.
   always_comb begin
      hit = 1'b0;
      hit_port = '0;
      for (int i = NPORT - 1; i >= 0; i--) begin
         if (match[i]) begin
            hit = 1'b1;
            hit_port = PW'(i);
         end
      end
   end

endmodule

`default_nettype wire

// *** src/lspr_router.sv ***
// Contract
// - Forward upstream, downstream, peer and reflection traffic.
// - Never forward primary ingress to primary egress.
// - Requests choose egress by address decode.
// - Responses routed from saved request state.
// - Other packets routed by port types.
// - Primary: forward down, answer, or drop.
// - Secondary: up, peer, reflect, answer, drop.
// - Each port has membership mask and default.
// - Same partition only when masks are mutual.
// - Overlapping partitions accepted without correction.
// - Without partitioning all ports share one.
// - Membership mask writable, reset to all.
// - Port type sampled from strap after reset.
// - Upstream ignores mask bits of primaries.
// - Secondary sends upstream to its default primary.
// - Upstream chosen by subtractive decode.
// - Forwarding may rewrite tag and compat.
// - Primary compat requests go to default port.
`timescale 1ns/1ps
`default_nettype none

module lspr_router
   import lspr_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rstn,
   // Port type straps, one bit per port, high for secondary.
   input wire logic [NPORT-1:0] port_sec_strap,
   // Register port.
   input wire logic [RAW-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Ingress packets.
   input wire logic in_valid,
   output logic in_ready,
   input wire lspr_pkt_s in_pkt,
   // Egress decisions.
   output logic out_valid,
   input wire logic out_ready,
   output lspr_out_s out_info
);

   // Every check below samples on the switch clock and sleeps while reset is low.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   // Router states.
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_DEC = 4'b0010,
      ST_CHK = 4'b0100,
      ST_OUT = 4'b1000
   } lspr_state_e;

   lspr_state_e state;
   lspr_pkt_s pkt_q; // Packet held while it is routed.
   lspr_act_e act_q; // Action proposed by the decode step.
   logic [PW-1:0] eg_q; // Egress proposed by the decode step.
   lspr_out_s out_q; // Registered result.

   // Configuration per port, plus the global partition enable.
   logic [NPORT-1:0][NPORT-1:0] mask;
   logic [NPORT-1:0][PW-1:0] dflt;
   logic [NPORT-1:0][AW-1:0] base;
   logic [NPORT-1:0][AW-1:0] limit;
   logic part_en;
   logic [NPORT-1:0] port_sec;

   // Strap synchroniser and capture.
   logic [NPORT-1:0] strap_s1, strap_s2, strap_s3;
   logic [1:0] settle;
   logic cfg_done;

   // Outstanding request table.
   logic [NTAG-1:0] tbl_valid;
   logic [NTAG-1:0][PW-1:0] tbl_port;
   logic [NTAG-1:0][TAGW-1:0] tbl_tag;

   // Decoder results.
   logic hit;
   logic [PW-1:0] hit_port;

   // Decode and check results.
   lspr_act_e dec_act, chk_act;
   logic [PW-1:0] dec_eg;
   logic chk_ok, need_tag, free_any, chk_go;
   logic [SLW-1:0] free_slot;
   logic [TAGW-1:0] out_tag;

   wire logic [PW-1:0] ing = pkt_q.port;
   wire logic ing_sec = port_sec[ing];
   wire logic np = is_np(pkt_q.kind);

   // Mutual membership, with reflection always legal.
   function automatic logic same_part(input logic [NPORT-1:0][NPORT-1:0] m,
                                      input logic en, input logic [PW-1:0] a,
                                      input logic [PW-1:0] b);
      return (a == b) || !en || (m[a][b] && m[b][a]);
   endfunction

   // Port register hit test, used for every per-port field on write and read.
   function automatic logic port_reg(input logic [RAW-1:0] a, input int p,
                                     input logic [RAW-1:0] off);
      return a == (RAW'(p) * REG_PORT_STRIDE + off);
   endfunction

   lspr_addr_dec u_dec (
      .addr(pkt_q.addr),
      .base(base),
      .limit(limit),
      .port_sec(port_sec),
      .hit(hit),
      .hit_port(hit_port)
   );

   // Straps pass three flops; the type is caught once the settle count is done and the last two agree.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         strap_s1 <= '0;
         strap_s2 <= '0;
         strap_s3 <= '0;
         settle <= '0;
         cfg_done <= 1'b0;
         port_sec <= PORT_SEC_RST;
      end else begin
         strap_s1 <= port_sec_strap;
         strap_s2 <= strap_s1;
         strap_s3 <= strap_s2;
         if (settle != STRAP_SETTLE) begin
            settle <= settle + 2'h1;
         end else if (!cfg_done && strap_s2 == strap_s3) begin
            port_sec <= strap_s3;
            cfg_done <= 1'b1;
         end
      end
   end

   // Per-port configuration registers written by software.
   genvar g;
   generate
      for (g = 0; g < NPORT; g++) begin : g_cfg
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               mask[g] <= MASK_RST;
               dflt[g] <= DFLT_RST;
               base[g] <= BASE_RST;
               limit[g] <= LIMIT_RST;
            end else if (reg_wr) begin
               // Any bitmap is stored as written; overlaps are not corrected.
               if (port_reg(reg_addr, g, REG_MASK)) begin
                  mask[g] <= reg_wdata[NPORT-1:0];
               end
               if (port_reg(reg_addr, g, REG_DFLT)) begin
                  dflt[g] <= reg_wdata[PW-1:0];
               end
               if (port_reg(reg_addr, g, REG_BASE)) begin
                  base[g] <= reg_wdata;
               end
               if (port_reg(reg_addr, g, REG_LIMIT)) begin
                  limit[g] <= reg_wdata;
               end
            end
         end
      end
   endgenerate

   // Global control register.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         part_en <= PART_EN_RST;
      end else if (reg_wr && reg_addr == REG_CTRL) begin
         part_en <= reg_wdata[CTRL_PART_EN_BIT];
      end
   end

   // Read data stand for one cycle after the strobe, zero otherwise.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= '0;
         if (reg_rd) begin
            for (int p = 0; p < NPORT; p++) begin
               if (port_reg(reg_addr, p, REG_MASK)) begin
                  reg_rdata <= 32'(mask[p]);
               end
               if (port_reg(reg_addr, p, REG_DFLT)) begin
                  reg_rdata <= 32'(dflt[p]);
               end
               if (port_reg(reg_addr, p, REG_BASE)) begin
                  reg_rdata <= base[p];
               end
               if (port_reg(reg_addr, p, REG_LIMIT)) begin
                  reg_rdata <= limit[p];
               end
               if (port_reg(reg_addr, p, REG_PSTAT)) begin
                  reg_rdata <= 32'(port_sec[p]) << PSTAT_SEC_BIT;
               end
            end
            if (reg_addr == REG_CTRL) begin
               reg_rdata <= 32'(part_en) << CTRL_PART_EN_BIT;
            end
            if (reg_addr == REG_GSTAT) begin
               reg_rdata <= 32'(tbl_valid);
            end
         end
      end
   end

   // Decode step: pick egress and action from kind, address and port types.
   always_comb begin
      dec_act = ACT_DROP;
      dec_eg = ing;
      case (pkt_q.kind)
         KIND_RESP: begin
            // Response path uses the table, never the response address.
            if (pkt_q.tag < TAGW'(NTAG) && tbl_valid[pkt_q.tag[SLW-1:0]]) begin
               dec_act = ACT_FWD;
               dec_eg = tbl_port[pkt_q.tag[SLW-1:0]];
            end
         end
         KIND_FLUSH, KIND_FENCE: begin
            if (ing_sec) begin
               dec_act = ACT_FWD;
               dec_eg = dflt[ing];
            end else begin
               dec_act = np ? ACT_RESP : ACT_DROP;
            end
         end
         KIND_RD_NP, KIND_WR_P, KIND_WR_NP: begin
            if (pkt_q.compat && !ing_sec) begin
               dec_act = ACT_FWD;
               dec_eg = dflt[ing];
            end else if (hit) begin
               dec_act = ACT_FWD;
               dec_eg = hit_port;
            end else if (ing_sec) begin
               // No secondary window claims it, so it leaves upstream.
               dec_act = ACT_FWD;
               dec_eg = dflt[ing];
            end else begin
               dec_act = np ? ACT_RESP : ACT_DROP;
            end
         end
         default: begin
            dec_act = np ? ACT_RESP : ACT_DROP;
         end
      endcase
   end

   // Check step: legality of the proposed egress.
   always_comb begin
      chk_ok = 1'b1;
      if (act_q == ACT_FWD) begin
         if (!ing_sec && !port_sec[eg_q]) begin
            chk_ok = 1'b0;
         end else if (ing_sec && !port_sec[eg_q]) begin
            // Primary mask bits play no part for upstream traffic.
            chk_ok = (eg_q == dflt[ing]);
         end else if (!(pkt_q.compat && !ing_sec)) begin
            chk_ok = same_part(mask, part_en, ing, eg_q);
         end else begin
            chk_ok = same_part(mask, part_en, ing, eg_q);
         end
      end
      if (act_q != ACT_FWD) begin
         chk_act = act_q;
      end else if (chk_ok) begin
         chk_act = ACT_FWD;
      end else begin
         chk_act = np ? ACT_RESP : ACT_DROP;
      end
   end

   // Free slot search for the request table.
   always_comb begin
      free_any = 1'b0;
      free_slot = '0;
      for (int i = NTAG - 1; i >= 0; i--) begin
         if (!tbl_valid[i]) begin
            free_any = 1'b1;
            free_slot = SLW'(i);
         end
      end
   end

   // A forwarded nonposted request waits in the check state for a free slot.
   assign need_tag = (chk_act == ACT_FWD) && np && (pkt_q.kind != KIND_RESP);
   assign chk_go = (state == ST_CHK) && (!need_tag || free_any);

   // Tag rewrite: nonposted requests carry the slot, responses get the original back.
   always_comb begin
      out_tag = pkt_q.tag;
      if (need_tag) begin
         out_tag = TAGW'(free_slot);
      end else if (chk_act == ACT_FWD && pkt_q.kind == KIND_RESP) begin
         out_tag = tbl_tag[pkt_q.tag[SLW-1:0]];
      end
   end

   // Request table; a forwarded response frees its slot when it leaves the check state.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tbl_valid <= '0;
         tbl_port <= '0;
         tbl_tag <= '0;
      end else if (chk_go) begin
         if (need_tag) begin
            tbl_valid[free_slot] <= 1'b1;
            tbl_port[free_slot] <= ing;
            tbl_tag[free_slot] <= pkt_q.tag;
         end else if (chk_act == ACT_FWD && pkt_q.kind == KIND_RESP) begin
            tbl_valid[pkt_q.tag[SLW-1:0]] <= 1'b0;
         end
      end
   end

   // Router sequence: take, decode, check, present.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= ST_IDLE;
         pkt_q <= '0;
         act_q <= ACT_DROP;
         eg_q <= '0;
         out_q <= '0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (in_valid && in_ready) begin
                  pkt_q <= in_pkt;
                  state <= ST_DEC;
               end
            end
            ST_DEC: begin
               act_q <= dec_act;
               eg_q <= dec_eg;
               state <= ST_CHK;
            end
            ST_CHK: begin
               // Nothing leaves before the membership check has settled.
               if (chk_go) begin
                  out_q.act <= chk_act;
                  out_q.ing <= ing;
                  out_q.port <= (chk_act == ACT_FWD) ? eg_q : ing;
                  out_q.pkt <= pkt_q;
                  out_q.pkt.tag <= out_tag;
                  // Compat is meaningless once a packet moves between secondaries.
                  out_q.pkt.compat <= pkt_q.compat && !(ing_sec && port_sec[eg_q]);
                  state <= ST_OUT;
               end
            end
            ST_OUT: begin
               if (out_ready) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   assign in_ready = (state == ST_IDLE) && cfg_done;
   assign out_valid = (state == ST_OUT);
   assign out_info = out_q;

   prim_to_prim_a: assert property (out_valid && out_info.act == ACT_FWD && !port_sec[out_info.ing]
      |-> port_sec[out_info.port]) else $error("primary to primary forward");
   up_default_a: assert property (out_valid && out_info.act == ACT_FWD && port_sec[out_info.ing]
      && !port_sec[out_info.port] |-> out_info.port == dflt[out_info.ing])
      else $error("upstream not to default port");
   part_mutual_a: assert property (out_valid && out_info.act == ACT_FWD && part_en
      && out_info.port != out_info.ing && port_sec[out_info.port]
      |-> mask[out_info.ing][out_info.port] && mask[out_info.port][out_info.ing])
      else $error("forward outside partition");
   check_hold_a: assert property (in_valid && in_ready |=> !out_valid ##1 !out_valid)
      else $error("packet left before check");
   resp_table_a: assert property (state == ST_DEC && pkt_q.kind == KIND_RESP && dec_act == ACT_FWD
      |=> eg_q == tbl_port[pkt_q.tag[SLW-1:0]]) else $error("response not from table");
   answer_home_a: assert property (out_valid && out_info.act == ACT_RESP
      |-> out_info.port == out_info.ing && is_np(out_info.pkt.kind))
      else $error("bad generated response");
   compat_route_a: assert property (state == ST_DEC && pkt_q.kind != KIND_RESP && pkt_q.compat
      && !ing_sec && pkt_q.kind != KIND_FLUSH && pkt_q.kind != KIND_FENCE
      |=> eg_q == dflt[pkt_q.port]) else $error("compat not to default port");
   addr_route_a: assert property (state == ST_DEC && hit && !pkt_q.compat && pkt_q.kind == KIND_WR_P
      |=> eg_q == $past(hit_port)) else $error("address decode ignored");
   out_stable_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_info))
      else $error("egress result changed while waiting");
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h00000000)
      else $error("read data outside slot");

   up_fwd_c: cover property (out_valid && out_info.act == ACT_FWD && !port_sec[out_info.port]);
   reflect_c: cover property (out_valid && out_info.act == ACT_FWD && port_sec[out_info.ing]
      && out_info.port == out_info.ing);
   resp_fwd_c: cover property (out_valid && out_info.act == ACT_FWD
      && out_info.pkt.kind == KIND_RESP);
   reject_c: cover property (state == ST_CHK && act_q == ACT_FWD && !chk_ok);

endmodule

`default_nettype wire

// *** dv/lspr_egress_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// Stand-in for the egress side: takes each routing decision after a set stall.
module lspr_egress_model
   import lspr_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rstn,
   // Decision handshake.
   input wire logic out_valid,
   output logic out_ready,
   // Cycles to hold off before accepting.
   input wire logic [3:0] stall
);
   logic [3:0] wait_cnt; // Cycles the pending decision has waited.

   // A slow receiver exposes a router that lets its decision drop early.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wait_cnt <= 4'h0;
      end else if (!out_valid || out_ready) begin
         wait_cnt <= 4'h0;
      end else begin
         wait_cnt <= wait_cnt + 4'h1;
      end
   end

   // Accept once the stall has run out.
   assign out_ready = out_valid && (wait_cnt >= stall);
endmodule

`default_nettype wire

// *** dv/link_switch_port_router_test.sv ***
`timescale 1ns/1ps
`default_nettype none

module link_switch_port_router_test
   import lspr_pkg::*;
;
   logic clk; // Switch clock.
   logic rstn; // Active-low reset.
   logic [RAW-1:0] reg_addr; // Register port.
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_rdata;
   logic in_valid; // Ingress handshake.
   logic in_ready;
   lspr_pkt_s in_pkt;
   logic out_valid; // Egress handshake.
   logic out_ready;
   lspr_out_s out_info;
   lspr_out_s seen; // Last decision taken.
   logic [3:0] stall; // Egress stall length.
   logic [NPORT-1:0] strap; // Port type strap, high for secondary.
   int bad_count;
   int check_count;

   lspr_router dut (.clk(clk), .rstn(rstn), .port_sec_strap(strap),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .in_valid(in_valid), .in_ready(in_ready), .in_pkt(in_pkt),
      .out_valid(out_valid), .out_ready(out_ready), .out_info(out_info));

   lspr_egress_model egress (.clk(clk), .rstn(rstn), .out_valid(out_valid),
      .out_ready(out_ready), .stall(stall));

   // Free-running switch clock.
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Compare one value and count it.
   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Address of a register in a port block.
   function automatic logic [RAW-1:0] pa(input int p, input logic [RAW-1:0] off);
      return off + REG_PORT_STRIDE * RAW'(p);
   endfunction

   task automatic wr(input logic [RAW-1:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe.
   task automatic rd(input logic [RAW-1:0] a, input logic [31:0] exp, input string what);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(what, reg_rdata, exp);
   endtask

   // Send one header, wait for the decision and judge action and ports.
   task automatic route(input lspr_kind_e k, input int p, input logic [AW-1:0] a,
      input lspr_act_e ea, input int ep, input logic [TAGW-1:0] t = 5'h11,
      input logic c = 1'b0);
      int n;
      @(posedge clk);
      in_valid <= 1'b1;
      in_pkt <= '{kind: k, port: PW'(p), addr: a, tag: t, compat: c};
      @(posedge clk);
      for (n = 0; n < 60 && in_ready !== 1'b1; n++) begin
         @(posedge clk);
      end
      in_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (out_valid !== 1'b1 && n < 60);
      chk("latency", 32'(n), 32'h3);
      while (out_ready !== 1'b1 && n < 90) begin
         @(posedge clk);
         n++;
      end
      chk("held valid", 32'(out_valid), 32'h1);
      seen = out_info;
      chk("action", 32'(seen.act), 32'(ea));
      chk("ingress", 32'(seen.ing), 32'(p));
      chk("kind", 32'(seen.pkt.kind), 32'(k));
      chk("address", seen.pkt.addr, a);
      if (ea == ACT_FWD) begin
         chk("egress", 32'(seen.port), 32'(ep));
      end
   endtask

   // Reset values, access kinds and the unmapped hole.
   task automatic t_regs();
      for (int p = 0; p < NPORT; p++) begin
         rd(pa(p, REG_MASK), 32'(MASK_RST), "mask");
         rd(pa(p, REG_DFLT), 32'(DFLT_RST), "dflt");
         rd(pa(p, REG_BASE), BASE_RST, "base");
         rd(pa(p, REG_LIMIT), LIMIT_RST, "limit");
         rd(pa(p, REG_PSTAT), 32'(PORT_SEC_RST[p]), "port type");
      end
      rd(REG_CTRL, 32'(PART_EN_RST), "ctrl");
      rd(REG_GSTAT, 32'h0, "table");
      rd(12'h1F0, 32'h0, "unmapped");
      wr(pa(1, REG_PSTAT), 32'h0);
      rd(pa(1, REG_PSTAT), 32'h1, "read-only type");
      wr(pa(3, REG_MASK), 32'hFFFFFFF7);
      rd(pa(3, REG_MASK), 32'h7, "mask write");
      wr(pa(3, REG_MASK), 32'hF);
   endtask

   // Downstream decode from the primary port.
   task automatic t_down();
      wr(pa(1, REG_BASE), 32'h1000);
      wr(pa(1, REG_LIMIT), 32'h1FFF);
      wr(pa(3, REG_BASE), 32'h3000);
      wr(pa(3, REG_LIMIT), 32'h3FFF);
      route(KIND_WR_P, 0, 32'h1800, ACT_FWD, 1);
      route(KIND_WR_P, 0, 32'h3FFF, ACT_FWD, 3);
      route(KIND_WR_P, 0, 32'h9000, ACT_DROP, 0);
      route(KIND_RD_NP, 0, 32'h9000, ACT_RESP, 0);
      route(KIND_WR_P, 0, 32'h1800, ACT_DROP, 0, 5'h11, 1'b1);
      wr(pa(0, REG_DFLT), 32'h3);
      route(KIND_WR_P, 0, 32'h1800, ACT_FWD, 3, 5'h11, 1'b1);
   endtask

   // Responses follow the saved request state; the request leaves under a slow egress.
   task automatic t_resp();
      stall <= 4'h4;
      route(KIND_RD_NP, 0, 32'h1800, ACT_FWD, 1);
      chk("new tag", 32'(seen.pkt.tag), 32'h0);
      rd(REG_GSTAT, 32'h1, "table busy");
      stall <= 4'h0;
      route(KIND_RESP, 1, 32'h0, ACT_FWD, 0, 5'h0);
      chk("old tag", 32'(seen.pkt.tag), 32'h11);
      rd(REG_GSTAT, 32'h0, "table free");
      route(KIND_RESP, 1, 32'h0, ACT_DROP, 0, 5'h3);
   endtask

   // Upstream, peer, reflection and typed routing; secondary defaults stay on port 0.
   task automatic t_sec();
      route(KIND_WR_P, 2, 32'h9000, ACT_FWD, 0);
      route(KIND_WR_P, 2, 32'h1800, ACT_FWD, 1, 5'h11, 1'b1);
      chk("compat", 32'(seen.pkt.compat), 32'h0);
      route(KIND_WR_P, 1, 32'h1800, ACT_FWD, 1);
      wr(pa(2, REG_MASK), 32'hC);
      route(KIND_WR_P, 2, 32'h9000, ACT_FWD, 0);
      wr(pa(2, REG_MASK), 32'hF);
      route(KIND_FLUSH, 0, 32'h0, ACT_RESP, 0);
      route(KIND_FENCE, 0, 32'h0, ACT_DROP, 0);
      route(KIND_FLUSH, 3, 32'h0, ACT_FWD, 0);
      route(KIND_FENCE, 3, 32'h0, ACT_FWD, 0);
   endtask

   // Membership: one-sided masks refuse, switching partitioning off admits.
   task automatic t_part();
      wr(pa(1, REG_MASK), 32'hB);
      route(KIND_WR_P, 2, 32'h1800, ACT_DROP, 0);
      route(KIND_RD_NP, 2, 32'h1800, ACT_RESP, 0);
      route(KIND_WR_P, 1, 32'h3800, ACT_FWD, 3);
      wr(REG_CTRL, 32'h0);
      route(KIND_WR_P, 2, 32'h1800, ACT_FWD, 1);
      wr(REG_CTRL, 32'h1);
      wr(pa(1, REG_MASK), 32'hF);
   endtask

   // A second reset samples a new strap; port 3 turns primary only after capture.
   task automatic t_strap();
      @(posedge clk);
      rstn <= 1'b0;
      strap <= 4'h6;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      #1;
      chk("ready before capture", 32'(in_ready), 32'h0);
      rd(pa(3, REG_PSTAT), 32'h1, "type before capture");
      repeat (4) @(posedge clk);
      rd(pa(3, REG_PSTAT), 32'h0, "type after capture");
      wr(pa(0, REG_DFLT), 32'h3);
      route(KIND_WR_P, 0, 32'h0, ACT_DROP, 0, 5'h11, 1'b1);
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Main sequence.
   initial begin
      rstn = 1'b0;
      reg_addr = 12'h000;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      in_valid = 1'b0;
      in_pkt = '0;
      stall = 4'h0;
      strap = PORT_SEC_RST;
      bad_count = 0;
      check_count = 0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      t_regs();
      t_down();
      t_resp();
      t_sec();
      t_part();
      t_strap();
      tally_and_finish();
   end

   // Cut a hang short; the whole run needs well under a thousand cycles.
   initial begin
      #(40 * 20000);
      bad_count++;
      tally_and_finish();
   end
endmodule

`default_nettype wire
